// [design/cdm_decoder.v]
// What this block does
// - reset leaves the nonmaskable mask set, blocking pin interrupts until software clears it.
// - nonmaskable acknowledge, after stacking, sets both the nonmaskable and maskable masks.
// - only reset or nonmaskable acknowledge can set the nonmaskable mask.
// - nonmaskable mask clears only by flags transfer or restore with bit 6 zero.
// - with stop-disable set, stop acts as no_operation; reset sets stop-disable.
// - a 16-bit word is two bytes, high byte at lower address.
// - fetches accept any byte address, no alignment required.
// - 8-bit opcodes on four pages; a prebyte moves decoding off page 0.
// - instruction is optional prebyte, opcode, zero to three operands: one to five bytes.
// - six addressing modes; all but inherent yield an effective address.
// - immediate operand follows opcode; address is the byte after the opcode.
// - direct uses one byte as low address, high byte zero.
// - extended takes the full address from the two bytes after the opcode.
// - indexed adds an unsigned 8-bit offset to the selected index register.
// - inherent carries everything in the opcode, one or two bytes.
// - taken branch adds signed 8-bit offset to the program counter, else falls through.
// - second index register use costs a prebyte and one extra cycle.
// - maskable mask set holds off maskable requests, which stay pending.
`timescale 1ns/1ps
`include "cdm_defs.vh"

module cdm_decoder (
	// clock and reset
	input wire I_CLOCK,
	input wire I_RSTN,
	// memory read port
	output reg [15:0] O_MEM_ADDR,
	output reg O_MEM_RD,
	input wire [7:0] I_MEM_DATA,
	input wire I_MEM_VALID,
	// opcode format lookup
	output reg [1:0] O_LOOKUP_PAGE,
	output reg [7:0] O_LOOKUP_OPCODE,
	input wire I_LOOKUP_PREBYTE,
	input wire [1:0] I_LOOKUP_NEXT_PAGE,
	input wire [2:0] I_LOOKUP_MODE,
	input wire [1:0] I_LOOKUP_OPERANDS,
	input wire I_LOOKUP_SECOND_INDEX,
	input wire I_LOOKUP_STOP,
	// index register values
	input wire [15:0] I_FIRST_INDEX,
	input wire [15:0] I_SECOND_INDEX,
	// decoded instruction
	output reg O_INSN_VALID,
	output reg [1:0] O_INSN_PAGE,
	output reg [7:0] O_INSN_OPCODE,
	output reg [2:0] O_INSN_MODE,
	output reg [2:0] O_INSN_LENGTH,
	output reg [23:0] O_INSN_OPERANDS,
	output reg [15:0] O_INSN_EA,
	output reg O_INSN_EA_VALID,
	output reg [15:0] O_INSN_NEXT_PC,
	output reg O_INSN_EXTRA_CYCLE,
	output reg O_STOP_REQ,
	// execution feedback
	input wire I_EXEC_DONE,
	input wire I_BRANCH_TAKEN,
	input wire I_PC_LOAD,
	input wire [15:0] I_PC_VALUE,
	// condition_flags_register mask writes
	input wire I_FLAGS_TRANSFER,
	input wire I_FLAGS_RESTORE,
	input wire [7:0] I_FLAGS_DATA,
	// interrupt handshakes
	input wire I_NMI_ACK,
	input wire I_IRQ_ACK,
	input wire I_NMI_PENDING,
	input wire I_IRQ_PENDING,
	// mask state
	output reg O_MASK_NMI,
	output reg O_MASK_IRQ,
	output reg O_STOP_DISABLE,
	output reg O_NMI_TAKE,
	output reg O_IRQ_TAKE
);
	// ==========================================================
	// states
	localparam ST_IDLE = 3'h0;
	localparam ST_OPC_REQ = 3'h1;
	localparam ST_OPC_WAIT = 3'h2;
	localparam ST_LOOK = 3'h3;
	localparam ST_OPR_REQ = 3'h4;
	localparam ST_OPR_WAIT = 3'h5;
	localparam ST_ISSUE = 3'h6;
	localparam ST_EXEC = 3'h7;

	reg [2:0] state_reg;
	reg [15:0] pc_reg;
	reg [15:0] opc_addr_reg;
	reg [1:0] page_reg;
	reg pre_reg;
	reg [7:0] opcode_reg;
	reg [2:0] mode_reg;
	reg [1:0] nops_reg;
	reg [1:0] left_reg;
	reg second_reg;
	reg stop_reg;
	reg [23:0] opr_reg;

	wire flags_write;
	wire [15:0] index_sel;
	wire [15:0] ea_calc;
	wire ea_valid_calc;
	wire [15:0] next_pc_calc;
	wire [2:0] length_calc;
	wire prebyte_hit;

	assign flags_write = I_FLAGS_TRANSFER | I_FLAGS_RESTORE;
	assign index_sel = second_reg ? I_SECOND_INDEX : I_FIRST_INDEX;
	assign length_calc = {2'b00, pre_reg} + 3'h1 + {1'b0, nops_reg};
	// one prebyte at most, and only from page 0
	assign prebyte_hit = I_LOOKUP_PREBYTE & (page_reg == `CDM_PAGE0) & ~pre_reg;

	// ==========================================================
	// address forming
	cdm_ea_calc u_ea_calc (
		.i_mode(mode_reg),
		.i_num_ops(nops_reg),
		.i_opc_addr(opc_addr_reg),
		.i_operands(opr_reg),
		.i_index(index_sel),
		.o_ea(ea_calc),
		.o_ea_valid(ea_valid_calc),
		.o_next_pc(next_pc_calc)
	);

	// ==========================================================
	// mask bits
	always @(posedge I_CLOCK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_MASK_NMI <= 1'b1;
			O_MASK_IRQ <= 1'b1;
			O_STOP_DISABLE <= 1'b1;
			O_NMI_TAKE <= 1'b0;
			O_IRQ_TAKE <= 1'b0;
		end else begin
			// set by acknowledge only, writes of one are ignored
			if (I_NMI_ACK) begin
				O_MASK_NMI <= 1'b1;
			end else if (flags_write && !I_FLAGS_DATA[`CDM_BIT_NMI]) begin
				O_MASK_NMI <= 1'b0;
			end
			// acknowledge wins over a same-cycle write
			if (I_NMI_ACK || I_IRQ_ACK) begin
				O_MASK_IRQ <= 1'b1;
			end else if (flags_write) begin
				O_MASK_IRQ <= I_FLAGS_DATA[`CDM_BIT_IRQ];
			end
			if (flags_write) begin
				O_STOP_DISABLE <= I_FLAGS_DATA[`CDM_BIT_STOP];
			end
			// pending requests wait while masked
			O_NMI_TAKE <= I_NMI_PENDING & ~O_MASK_NMI;
			O_IRQ_TAKE <= I_IRQ_PENDING & ~O_MASK_IRQ;
		end
	end

	// ==========================================================
	// fetch and decode sequencer
	always @(posedge I_CLOCK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			state_reg <= ST_IDLE;
			pc_reg <= `CDM_ADDR_ZERO;
			opc_addr_reg <= `CDM_ADDR_ZERO;
			page_reg <= `CDM_PAGE0;
			pre_reg <= 1'b0;
			opcode_reg <= 8'h00;
			mode_reg <= `CDM_MODE_INH;
			nops_reg <= `CDM_OPS_NONE;
			left_reg <= `CDM_OPS_NONE;
			second_reg <= 1'b0;
			stop_reg <= 1'b0;
			opr_reg <= 24'h00_0000;
			O_MEM_ADDR <= `CDM_ADDR_ZERO;
			O_MEM_RD <= 1'b0;
			O_LOOKUP_PAGE <= `CDM_PAGE0;
			O_LOOKUP_OPCODE <= 8'h00;
			O_INSN_VALID <= 1'b0;
			O_INSN_PAGE <= `CDM_PAGE0;
			O_INSN_OPCODE <= 8'h00;
			O_INSN_MODE <= `CDM_MODE_INH;
			O_INSN_LENGTH <= 3'h0;
			O_INSN_OPERANDS <= 24'h00_0000;
			O_INSN_EA <= `CDM_ADDR_ZERO;
			O_INSN_EA_VALID <= 1'b0;
			O_INSN_NEXT_PC <= `CDM_ADDR_ZERO;
			O_INSN_EXTRA_CYCLE <= 1'b0;
			O_STOP_REQ <= 1'b0;
		end else begin
			O_MEM_RD <= 1'b0;
			O_INSN_VALID <= 1'b0;
			O_STOP_REQ <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (I_PC_LOAD) begin
						pc_reg <= I_PC_VALUE;
						page_reg <= `CDM_PAGE0;
						pre_reg <= 1'b0;
						state_reg <= ST_OPC_REQ;
					end
				end
				ST_OPC_REQ: begin
					O_MEM_ADDR <= pc_reg;
					O_MEM_RD <= 1'b1;
					state_reg <= ST_OPC_WAIT;
				end
				ST_OPC_WAIT: begin
					if (I_MEM_VALID) begin
						opcode_reg <= I_MEM_DATA;
						O_LOOKUP_OPCODE <= I_MEM_DATA;
						O_LOOKUP_PAGE <= page_reg;
						state_reg <= ST_LOOK;
					end
				end
				ST_LOOK: begin
					pc_reg <= pc_reg + `CDM_ADDR_ONE;
					if (prebyte_hit) begin
						page_reg <= I_LOOKUP_NEXT_PAGE;
						pre_reg <= 1'b1;
						state_reg <= ST_OPC_REQ;
					end else begin
						opc_addr_reg <= pc_reg;
						mode_reg <= I_LOOKUP_MODE;
						nops_reg <= I_LOOKUP_OPERANDS;
						left_reg <= I_LOOKUP_OPERANDS;
						second_reg <= I_LOOKUP_SECOND_INDEX & pre_reg;
						stop_reg <= I_LOOKUP_STOP;
						opr_reg <= 24'h00_0000;
						if (I_LOOKUP_OPERANDS == `CDM_OPS_NONE) begin
							state_reg <= ST_ISSUE;
						end else begin
							state_reg <= ST_OPR_REQ;
						end
					end
				end
				ST_OPR_REQ: begin
					O_MEM_ADDR <= pc_reg;
					O_MEM_RD <= 1'b1;
					state_reg <= ST_OPR_WAIT;
				end
				ST_OPR_WAIT: begin
					if (I_MEM_VALID) begin
						// earlier bytes shift up, first byte ends most significant
						opr_reg <= {opr_reg[15:0], I_MEM_DATA};
						pc_reg <= pc_reg + `CDM_ADDR_ONE;
						left_reg <= left_reg - `CDM_OPS_ONE;
						if (left_reg == `CDM_OPS_ONE) begin
							state_reg <= ST_ISSUE;
						end else begin
							state_reg <= ST_OPR_REQ;
						end
					end
				end
				ST_ISSUE: begin
					page_reg <= `CDM_PAGE0;
					pre_reg <= 1'b0;
					if (stop_reg && O_STOP_DISABLE) begin
						// no_operation: straight on to the next opcode
						state_reg <= ST_OPC_REQ;
					end else begin
						O_INSN_VALID <= 1'b1;
						O_INSN_PAGE <= page_reg;
						O_INSN_OPCODE <= opcode_reg;
						O_INSN_MODE <= mode_reg;
						O_INSN_LENGTH <= length_calc;
						O_INSN_OPERANDS <= opr_reg;
						O_INSN_EA <= ea_calc;
						O_INSN_EA_VALID <= ea_valid_calc;
						O_INSN_NEXT_PC <= next_pc_calc;
						O_INSN_EXTRA_CYCLE <= second_reg;
						O_STOP_REQ <= stop_reg;
						state_reg <= ST_EXEC;
					end
				end
				default: begin
					if (I_PC_LOAD) begin
						pc_reg <= I_PC_VALUE;
						state_reg <= ST_OPC_REQ;
					end else if (I_EXEC_DONE) begin
						if (O_INSN_MODE == `CDM_MODE_REL && I_BRANCH_TAKEN) begin
							pc_reg <= O_INSN_EA;
						end else begin
							pc_reg <= O_INSN_NEXT_PC;
						end
						state_reg <= ST_OPC_REQ;
					end
				end
			endcase
		end
	end
endmodule // cdm_decoder

// [design/cdm_defs.vh]
`ifndef CDM_DEFS_VH
`define CDM_DEFS_VH

// ==========================================================
// address and data widths
`define CDM_ADDR_W 16
`define CDM_ADDR_ZERO 16'h0000
`define CDM_ADDR_ONE 16'h0001
`define CDM_DIRECT_HIGH 8'h00

// ==========================================================
// addressing modes
`define CDM_MODE_IMM 3'h0
`define CDM_MODE_DIR 3'h1
`define CDM_MODE_EXT 3'h2
`define CDM_MODE_IDX 3'h3
`define CDM_MODE_INH 3'h4
`define CDM_MODE_REL 3'h5

// ==========================================================
// opcode pages and operand counts
`define CDM_PAGE0 2'h0
`define CDM_OPS_NONE 2'h0
`define CDM_OPS_ONE 2'h1
`define CDM_OPS_TWO 2'h2
`define CDM_OPS_THREE 2'h3

// ==========================================================
// bit positions inside the condition_flags_register byte
`define CDM_BIT_STOP 7
`define CDM_BIT_NMI 6
`define CDM_BIT_IRQ 4

`endif

// [design/cdm_ea_calc.v]
`timescale 1ns/1ps
`include "cdm_defs.vh"

// ==========================================================
// effective address and next instruction address
module cdm_ea_calc (
	// decoded instruction
	input wire [2:0] i_mode,
	input wire [1:0] i_num_ops,
	input wire [15:0] i_opc_addr,
	input wire [23:0] i_operands,
	// selected index value
	input wire [15:0] i_index,
	// results
	output reg [15:0] o_ea,
	output reg o_ea_valid,
	output reg [15:0] o_next_pc
);
	reg [7:0] first_byte;
	reg [7:0] second_byte;
	reg [7:0] last_byte;
	reg [15:0] rel_offset;

	always @* begin
		first_byte = i_operands[7:0];
		second_byte = 8'h00;
		last_byte = i_operands[7:0];
		if (i_num_ops == `CDM_OPS_TWO) begin
			first_byte = i_operands[15:8];
			second_byte = i_operands[7:0];
		end else if (i_num_ops == `CDM_OPS_THREE) begin
			first_byte = i_operands[23:16];
			second_byte = i_operands[15:8];
		end
		// any byte address is legal, plain 16-bit wrap
		o_next_pc = i_opc_addr + `CDM_ADDR_ONE + {14'h0000, i_num_ops};
		rel_offset = {{8{last_byte[7]}}, last_byte};
		o_ea = `CDM_ADDR_ZERO;
		o_ea_valid = 1'b1;
		case (i_mode)
			`CDM_MODE_IMM: o_ea = i_opc_addr + `CDM_ADDR_ONE;
			`CDM_MODE_DIR: o_ea = {`CDM_DIRECT_HIGH, first_byte};
			`CDM_MODE_EXT: o_ea = {first_byte, second_byte};
			`CDM_MODE_IDX: o_ea = i_index + {8'h00, first_byte};
			`CDM_MODE_REL: o_ea = o_next_pc + rel_offset;
			default: begin
				o_ea_valid = 1'b0;
			end
		endcase
	end
endmodule // cdm_ea_calc

// [sim/cdm_chk.sv]
`timescale 1ns/1ps
`include "cdm_defs.vh"
module cdm_chk (
	// clock and reset
	input wire I_CLOCK,
	input wire I_RSTN,
	// flag writes and masks
	input wire I_FLAGS_TRANSFER,
	input wire I_FLAGS_RESTORE,
	input wire [7:0] I_FLAGS_DATA,
	input wire I_NMI_ACK,
	input wire O_MASK_NMI,
	input wire O_MASK_IRQ,
	input wire O_STOP_DISABLE,
	// decoded instruction
	input wire O_STOP_REQ,
	input wire O_INSN_VALID,
	input wire [2:0] O_INSN_MODE,
	input wire [2:0] O_INSN_LENGTH,
	input wire [23:0] O_INSN_OPERANDS,
	input wire [15:0] O_INSN_EA,
	input wire O_INSN_EA_VALID,
	input wire [15:0] O_INSN_NEXT_PC
);
default clocking cb @(posedge I_CLOCK); endclocking
default disable iff (!I_RSTN);
wire clr = (I_FLAGS_TRANSFER | I_FLAGS_RESTORE) & ~I_FLAGS_DATA[`CDM_BIT_NMI];
wire [7:0] lo = O_INSN_OPERANDS[7:0];
wire v = O_INSN_VALID;
a_reset_masks: assert property ($rose(I_RSTN) |-> O_MASK_NMI && O_MASK_IRQ && O_STOP_DISABLE)
	else $error("masks not set after reset");
a_nmi_ack: assert property (I_NMI_ACK |=> O_MASK_NMI && O_MASK_IRQ)
	else $error("ack did not set both masks");
a_nmi_noset: assert property (!O_MASK_NMI && !I_NMI_ACK |=> !O_MASK_NMI)
	else $error("nmi mask set without ack");
a_nmi_clear: assert property (clr && !I_NMI_ACK |=> !O_MASK_NMI)
	else $error("nmi mask not cleared by write");
a_nmi_keep: assert property (O_MASK_NMI && !clr |=> O_MASK_NMI)
	else $error("nmi mask cleared without write");
a_stop_nop: assert property (O_STOP_REQ |-> v && !$past(O_STOP_DISABLE))
	else $error("stop issued while disabled");
a_len_range: assert property (v |-> O_INSN_LENGTH >= 3'h1 && O_INSN_LENGTH <= 3'h5)
	else $error("length out of range");
a_inh_noea: assert property (v |-> O_INSN_EA_VALID == (O_INSN_MODE != `CDM_MODE_INH))
	else $error("ea valid wrong for mode");
a_dir_page: assert property (v && O_INSN_MODE == `CDM_MODE_DIR |-> O_INSN_EA == {8'h00, lo})
	else $error("direct ea wrong");
a_ext_word: assert property (v && O_INSN_MODE == `CDM_MODE_EXT |-> O_INSN_EA == O_INSN_OPERANDS[15:0])
	else $error("extended ea wrong");
a_rel_wrap: assert property (v && O_INSN_MODE == `CDM_MODE_REL
	|-> O_INSN_EA == O_INSN_NEXT_PC + {{8{lo[7]}}, lo})
	else $error("branch target wrong");
endmodule // cdm_chk

// [sim/cdm_mem_model.sv]
`timescale 1ns/1ps
// ==========================================================
// byte memory, answers each read after latency cycles
module cdm_mem_model (
	// clock and reset
	input wire i_clk,
	input wire i_rstn,
	// read port
	input wire i_rd,
	input wire [15:0] i_addr,
	output reg [7:0] o_data,
	output reg o_valid
);
reg [7:0] mem [0:65535];
reg [3:0] latency = 4'h1;
reg [3:0] cnt_reg;
reg [15:0] addr_reg;
always @(posedge i_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		cnt_reg <= 4'h0;
		o_valid <= 1'b0;
		o_data <= 8'h00;
	end else begin
		o_valid <= 1'b0;
		// data toggles while not valid
		o_data <= ~o_data;
		if (i_rd) begin
			cnt_reg <= latency;
			addr_reg <= i_addr;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
			if (cnt_reg == 4'h1) begin
				o_valid <= 1'b1;
				o_data <= mem[addr_reg];
			end
		end
	end
end
endmodule // cdm_mem_model

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
reg clk = 1'b0;
reg rstn = 1'b0;
reg ed = 1'b0;
reg bt = 1'b0;
reg pl = 1'b0;
reg [15:0] pv = 16'h0000;
reg xf = 1'b0;
reg rs = 1'b0;
reg [7:0] fd = 8'h00;
reg na = 1'b0;
reg ia = 1'b0;
reg np = 1'b0;
reg ip = 1'b0;
integer error_cnt = 0;
integer samples_checked = 0;
wire [15:0] ma, ea, npc;
wire [23:0] op;
wire rd, mv, v, eav, xc, sq, mn, mi, sd, nt, it;
wire [7:0] md8, lo, opc;
wire [1:0] lp, pg;
wire [2:0] md, len;
always #2.5 clk = ~clk;
cdm_mem_model mem_i (.i_clk(clk), .i_rstn(rstn), .i_rd(rd), .i_addr(ma), .o_data(md8),
	.o_valid(mv));
cdm_decoder dut (.I_CLOCK(clk), .I_RSTN(rstn), .O_MEM_ADDR(ma), .O_MEM_RD(rd),
	.I_MEM_DATA(md8), .I_MEM_VALID(mv), .O_LOOKUP_PAGE(lp), .O_LOOKUP_OPCODE(lo),
	.I_LOOKUP_PREBYTE(lp == 2'h0 && lo == 8'h18), .I_LOOKUP_NEXT_PAGE(2'h1),
	.I_LOOKUP_MODE(lo[2:0]), .I_LOOKUP_OPERANDS(lo[4:3]), .I_LOOKUP_SECOND_INDEX(lo[5]),
	.I_LOOKUP_STOP(lo == 8'hc4), .I_FIRST_INDEX(16'h1234), .I_SECOND_INDEX(16'hfff8),
	.O_INSN_VALID(v), .O_INSN_PAGE(pg), .O_INSN_OPCODE(opc), .O_INSN_MODE(md),
	.O_INSN_LENGTH(len), .O_INSN_OPERANDS(op), .O_INSN_EA(ea), .O_INSN_EA_VALID(eav),
	.O_INSN_NEXT_PC(npc), .O_INSN_EXTRA_CYCLE(xc), .O_STOP_REQ(sq), .I_EXEC_DONE(ed),
	.I_BRANCH_TAKEN(bt), .I_PC_LOAD(pl), .I_PC_VALUE(pv), .I_FLAGS_TRANSFER(xf),
	.I_FLAGS_RESTORE(rs), .I_FLAGS_DATA(fd), .I_NMI_ACK(na), .I_IRQ_ACK(ia),
	.I_NMI_PENDING(np), .I_IRQ_PENDING(ip), .O_MASK_NMI(mn), .O_MASK_IRQ(mi),
	.O_STOP_DISABLE(sd), .O_NMI_TAKE(nt), .O_IRQ_TAKE(it));
// ==========================================================
// shared tasks
task chk(input logic [23:0] g, input logic [23:0] e);
	begin
	samples_checked = samples_checked + 1;
	if (g !== e) begin
		error_cnt = error_cnt + 1;
		$display("mismatch at %0t: got %h expected %h", $time, g, e);
	end
	end
endtask
task wrap_up;
	begin
	$display("checked %0d mismatches %0d", samples_checked, error_cnt);
	if (error_cnt == 0 && samples_checked > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
	end
endtask
task await(input integer sel);
	integer n;
	begin
	n = 0;
	while ((sel ? rd : v) !== 1'b1 && n < 300) begin
		@(posedge clk);
		#1;
		n = n + 1;
	end
	if (n >= 300) begin
		error_cnt = error_cnt + 1;
		$display("mismatch at %0t: wait timed out", $time);
		wrap_up;
	end
	end
endtask
task ld(input [15:0] a, input [7:0] b0, input [7:0] b1, input [7:0] b2);
	begin
	mem_i.mem[a] = b0;
	mem_i.mem[a + 16'h0001] = b1;
	mem_i.mem[a + 16'h0002] = b2;
	end
endtask
task run(input [15:0] a);
	begin
	@(negedge clk);
	pl = 1'b1;
	pv = a;
	@(negedge clk);
	pl = 1'b0;
	await(0);
	end
endtask
task ins(input [2:0] m, input [2:0] l, input [15:0] e, input ev, input [15:0] n, input x);
	begin
	chk(24'(md), 24'(m));
	chk(24'(len), 24'(l));
	chk(24'(eav), 24'(ev));
	if (ev)
		chk(24'(ea), 24'(e));
	chk(24'(npc), 24'(n));
	chk(24'(xc), 24'(x));
	end
endtask
task fl(input t, input r, input [7:0] d, input a, input q);
	begin
	@(negedge clk);
	{xf, rs, fd, na, ia} = {t, r, d, a, q};
	@(negedge clk);
	{xf, rs, na, ia} = 4'h0;
	end
endtask
task br(input t, input [15:0] exp);
	begin
	@(negedge clk);
	{ed, bt} = {1'b1, t};
	@(negedge clk);
	{ed, bt} = 2'h0;
	await(1);
	chk(24'(ma), 24'(exp));
	await(0);
	end
endtask
// ==========================================================
// scenarios
task t_modes;
	begin
	ld(16'h1001, 8'h09, 8'h5a, 8'h00);
	run(16'h1001);
	ins(3'h1, 3'h2, 16'h005a, 1'b1, 16'h1003, 1'b0);
	mem_i.latency = 4'h6;
	ld(16'h2fff, 8'h12, 8'hab, 8'hcd);
	run(16'h2fff);
	ins(3'h2, 3'h3, 16'habcd, 1'b1, 16'h3002, 1'b0);
	chk(op, 24'h00_abcd);
	mem_i.latency = 4'h1;
	ld(16'h4003, 8'h18, 8'h08, 8'h77);
	run(16'h4003);
	ins(3'h0, 3'h3, 16'h4005, 1'b1, 16'h4006, 1'b0);
	chk(24'(pg), 24'h00_0001);
	ld(16'h7000, 8'h18, 8'h2b, 8'h10);
	run(16'h7000);
	ins(3'h3, 3'h3, 16'h0008, 1'b1, 16'h7003, 1'b1);
	ld(16'h7100, 8'h2b, 8'hf0, 8'h00);
	run(16'h7100);
	ins(3'h3, 3'h2, 16'h1324, 1'b1, 16'h7102, 1'b0);
	$display("modes done");
	end
endtask
task t_branch;
	begin
	ld(16'h0002, 8'h0d, 8'h80, 8'h04);
	ld(16'hff84, 8'h04, 8'h04, 8'h04);
	run(16'h0002);
	ins(3'h5, 3'h2, 16'hff84, 1'b1, 16'h0004, 1'b0);
	br(1'b1, 16'hff84);
	run(16'h0002);
	br(1'b0, 16'h0004);
	ins(3'h4, 3'h1, 16'h0000, 1'b0, 16'h0005, 1'b0);
	$display("branch done");
	end
endtask
task t_stop;
	begin
	ld(16'h6000, 8'hc4, 8'h04, 8'h00);
	run(16'h6000);
	chk(24'(opc), 24'h00_0004);
	chk(24'(sq), 24'h00_0000);
	fl(1'b1, 1'b0, 8'h50, 1'b0, 1'b0);
	chk(24'({sd, mn, mi}), 24'h00_0003);
	run(16'h6000);
	chk(24'({opc, sq}), 24'h00_0189);
	$display("stop done");
	end
endtask
task t_flags;
	begin
	fl(1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
	chk(24'({mn, mi}), 24'h00_0000);
	fl(1'b1, 1'b0, 8'h40, 1'b0, 1'b0);
	chk(24'(mn), 24'h00_0000);
	ip = 1'b1;
	repeat (2) @(negedge clk);
	chk(24'(it), 24'h00_0001);
	fl(1'b1, 1'b0, 8'h00, 1'b1, 1'b0);
	np = 1'b1;
	repeat (2) @(negedge clk);
	chk(24'({mn, mi, it, nt}), 24'h00_000c);
	fl(1'b0, 1'b1, 8'h90, 1'b0, 1'b0);
	repeat (2) @(negedge clk);
	chk(24'({mn, mi, nt}), 24'h00_0003);
	// maskable acknowledge beats a same-cycle write of zero
	fl(1'b1, 1'b0, 8'h00, 1'b0, 1'b1);
	chk(24'({mn, mi}), 24'h00_0001);
	$display("flags done");
	end
endtask
initial begin
	repeat (2) @(negedge clk);
	rstn = 1'b1;
	chk(24'({mn, mi, sd}), 24'h00_0007);
	t_modes;
	t_branch;
	t_stop;
	t_flags;
	wrap_up;
end
endmodule // tb
bind cdm_decoder cdm_chk chk_i (.I_CLOCK, .I_RSTN, .I_FLAGS_TRANSFER, .I_FLAGS_RESTORE,
	.I_FLAGS_DATA, .I_NMI_ACK, .O_MASK_NMI, .O_MASK_IRQ, .O_STOP_DISABLE, .O_STOP_REQ,
	.O_INSN_VALID, .O_INSN_MODE, .O_INSN_LENGTH, .O_INSN_OPERANDS, .O_INSN_EA,
	.O_INSN_EA_VALID, .O_INSN_NEXT_PC);
